// [dv/fpm_supply_model.sv]
/*
 * fpm_supply_model: supplies, sleep pin, straps and shorted outputs as the block sees them.
 * assumes the bench sets the conditions; a short draws current only while bridges drive.
 */
`timescale 1ns/1ps
module fpm_supply_model
	import fpm_pkg::*;
(
	// conditions from the bench
	input  wire logic       motor_low,
	input  wire logic       pump_low,
	input  wire logic       logic_low,
	input  wire logic       sleep_n,
	input  wire logic       hw_mode,
	input  wire logic       en_high,
	input  wire logic [3:0] short_vm,
	input  wire logic [3:0] short_gnd,
	// from the block
	input  wire logic       bridge_hiz,
	// to the block
	output wire fpm_pins_t  pins
);
	assign pins.motor_uv          = motor_low;
	assign pins.pump_uv           = pump_low;
	assign pins.logic_uv          = logic_low;
	assign pins.sleep_reset_pin_n = sleep_n;
	assign pins.hw_mode           = hw_mode;
	assign pins.enable_high       = en_high;
	// no current once the bridge is off, so a limit never outlives the shutdown
	assign pins.limit_low         = bridge_hiz ? 4'h0 : short_vm;
	assign pins.limit_high        = bridge_hiz ? 4'h0 : short_gnd;
endmodule : fpm_supply_model

// [dv/tb_fpm_fault_manager.sv]
/*
 * tb_fpm_fault_manager: self-checking bench with a register model of the status bits.
 * assumes a pin condition reaches the outputs 3 cycles after its edge.
 */
`timescale 1ns/1ps
module tb_fpm_fault_manager
	import fpm_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        silent_step_active = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        fault_out_n, bridge_hiz, pump_off, dither_on;
	logic [3:0]  dither_step;
	fpm_pins_t   pins;
	logic        motor_low = 1'b0, pump_low = 1'b0, logic_low = 1'b0;
	logic        sleep_n = 1'b1, hw_mode = 1'b0, en_high = 1'b0;
	logic [3:0]  short_vm = 4'h0, short_gnd = 4'h0;
	logic [31:0] rd, ctl, rng = 32'd69692;
	logic [7:0]  p;
	int          errors = 0, compares = 0, cycles = 0;
	int          m_fault = 0, m_supply = 0, m_pump = 0, m_lok = 0, m_oc = 0, m_flags = 0;
	int          deg, d, prev, lo, hi;

	fpm_fault_manager #(.RETRY_CYCLES(20)) i_fpm_fault_manager (
		.core_clk(core_clk), .rst(rst), .pins(pins), .silent_step_active(silent_step_active),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .fault_out_n(fault_out_n), .bridge_hiz(bridge_hiz),
		.pump_off(pump_off), .dither_on(dither_on), .dither_step(dither_step));

	fpm_supply_model i_fpm_supply_model (
		.motor_low(motor_low), .pump_low(pump_low), .logic_low(logic_low), .sleep_n(sleep_n),
		.hw_mode(hw_mode), .en_high(en_high), .short_vm(short_vm), .short_gnd(short_gnd),
		.bridge_hiz(bridge_hiz), .pins(pins));

	always #2.5 core_clk = ~core_clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	task automatic report_and_stop();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
	endtask : step

	// hold the request until waitrequest is sampled low, then release;
	// no local limit, a hung bus is ended by the run's cycle ceiling
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
			output logic [31:0] q);
		@(posedge core_clk);
		avs_read      <= !wr;
		avs_write     <= wr;
		avs_address   <= a;
		avs_writedata <= wd;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic st_chk();
		bus(1'b0, STATUS_OFS, 32'h0, rd);
		chk("status", rd, 32'((m_fault << ST_FAULT_POS) | (m_supply << ST_SUPPLY_POS) |
			(m_pump << ST_PUMP_POS) | (m_lok << ST_LOGIC_OK_POS) | (m_oc << ST_OVERCUR_POS)));
		bus(1'b0, OCFLAG_OFS, 32'h0, rd);
		chk("oc flags", rd, 32'(m_flags));
	endtask : st_chk

	// latched bits fall unless their condition still holds
	task automatic mclr();
		m_supply = motor_low;
		m_pump   = pump_low;
		m_lok    = !logic_low;
		m_oc     = 0;
		m_flags  = 0;
		m_fault  = motor_low | pump_low;
	endtask : mclr

	task automatic clear();
		bus(1'b1, CONTROL_OFS, ctl | (32'h1 << CT_CLEAR_POS), rd);
		mclr();
	endtask : clear

	task automatic outs(input logic [2:0] e);
		step(5);
		chk("hiz pump fault_n", {29'h0, bridge_hiz, pump_off, fault_out_n}, {29'h0, e});
	endtask : outs

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			$display("ERROR %0t run too long", $time);
			report_and_stop();
		end
	end

	initial begin
		step(4);
		#1;
		chk("reset outs", {bridge_hiz, pump_off, fault_out_n, avs_waitrequest}, 4'hf);
		chk("reset dither", {dither_on, dither_step}, {1'b0, DITHER_CENTER});
		step(4);
		rst <= 1'b0;
		step(1);
		#1;
		chk("boot fault_n", fault_out_n, 1'b0);
		outs(3'b001);
		st_chk();
		ctl = 32'h1;
		bus(1'b0, CONTROL_OFS, 32'h0, rd);
		chk("control reset", rd, ctl);
		bus(1'b0, 4'hc, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		bus(1'b1, 4'hc, 32'hffffffff, rd);
		bus(1'b1, STATUS_OFS, 32'hffffffff, rd);
		bus(1'b0, CONTROL_OFS, 32'h0, rd);
		chk("control kept", rd, ctl);
		clear();
		st_chk();
		bus(1'b0, CONTROL_OFS, 32'h0, rd);
		chk("clear self", rd, ctl);
		motor_low <= 1'b1;
		m_supply = 1;
		m_fault = 1;
		outs(3'b110);
		st_chk();
		motor_low <= 1'b0;
		m_fault = 0;
		outs(3'b001);
		st_chk();
		clear();
		st_chk();
		pump_low <= 1'b1;
		m_pump = 1;
		m_fault = 1;
		outs(3'b100);
		st_chk();
		pump_low <= 1'b0;
		m_fault = 0;
		outs(3'b001);
		st_chk();
		sleep_n <= 1'b0;
		step(4);
		sleep_n <= 1'b1;
		step(5);
		mclr();
		st_chk();
		logic_low <= 1'b1;
		m_lok = 0;
		outs(3'b111);
		logic_low <= 1'b0;
		outs(3'b001);
		st_chk();
		clear();
		st_chk();
		for (int s = 0; s < 5; s++) begin
			deg = int'(OC_DEG0_CYC) << (s % 4);
			ctl = (s == 4) ? 32'h3 : 32'(1 | (s << CT_DEGLITCH_POS));
			bus(1'b1, CONTROL_OFS, ctl, rd);
			rng = xs(rng);
			p = (rng[7:0] == 8'h0) ? 8'h1 : rng[7:0];
			short_vm  <= p[3:0];
			short_gnd <= p[7:4];
			step(deg + 2);
			chk("before deglitch", fault_out_n, 1'b1);
			outs(3'b100);
			short_vm  <= 4'h0;
			short_gnd <= 4'h0;
			m_fault = 1;
			m_oc = 1;
			m_flags = p;
			st_chk();
			step(5);
			chk("still off", bridge_hiz, 1'b1);
			if (s == 4) begin
				step(20);
				m_fault = 0;
				outs(3'b001);
				st_chk();
			end
			clear();
			outs(3'b001);
			st_chk();
		end
		ctl = 32'h0;
		bus(1'b1, CONTROL_OFS, ctl, rd);
		step(3);
		chk("dither on", dither_on, 1'b1);
		prev = dither_step;
		lo = prev;
		hi = prev;
		repeat (6000) begin
			@(posedge core_clk);
			d = dither_step;
			if (d != prev) chk("dither delta", 32'((d > prev) ? d - prev : prev - d), 32'h1);
			lo = (d < lo) ? d : lo;
			hi = (d > hi) ? d : hi;
			prev = d;
		end
		chk("dither range", {lo[3:0], hi[3:0]}, {4'h0, DITHER_TOP});
		silent_step_active <= 1'b1;
		step(3);
		chk("silent dither", {dither_on, dither_step}, {1'b0, DITHER_CENTER});
		silent_step_active <= 1'b0;
		hw_mode <= 1'b1;
		step(6);
		chk("hw dither", dither_on, 1'b0);
		// strapped mode: the enable pin picks the overcurrent response, live
		en_high   <= 1'b1;
		short_gnd <= 4'h2;
		step(int'(OC_DEG0_CYC) + 5);
		chk("hw declare", {bridge_hiz, fault_out_n}, 2'b10);
		short_gnd <= 4'h0;
		en_high   <= 1'b0;
		step(40);
		chk("hw latched", {bridge_hiz, fault_out_n}, 2'b10);
		en_high <= 1'b1;
		m_oc    = 1;
		m_flags = 32'h20;
		step(30);
		outs(3'b001);
		st_chk();
		// core reset while the motor supply is low
		rst       <= 1'b1;
		motor_low <= 1'b1;
		step(3);
		chk("mid reset outs", {bridge_hiz, pump_off, fault_out_n, avs_waitrequest}, 4'hf);
		rst <= 1'b0;
		m_fault  = 1;
		m_supply = 0;
		m_lok    = 0;
		m_oc     = 0;
		m_flags  = 0;
		outs(3'b110);
		st_chk();
		bus(1'b0, CONTROL_OFS, 32'h0, rd);
		chk("control after reset", rd, 32'h1);
		motor_low <= 1'b0;
		m_fault = 0;
		outs(3'b001);
		st_chk();
		report_and_stop();
	end
endmodule : tb_fpm_fault_manager

// [hw/fpm_fault_manager.sv]
/*
 * fpm_fault_manager: supply, charge pump, logic supply and overcurrent
 * supervision with latched status, fault pin and clock dither control.
 * assumes analog comparator outputs and straps arrive asynchronously and
 * that rst is held while the core supply is below its reset level.
 */
`timescale 1ns/1ps
module fpm_fault_manager
	import fpm_pkg::*;
#(
	parameter int RETRY_CYCLES = RETRY_CYC
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// analog comparators and straps
	input  wire fpm_pins_t   pins,
	// decay logic, same clock
	input  wire logic        silent_step_active,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// power stage and pins
	output logic             fault_out_n,
	output logic             bridge_hiz,
	output logic             pump_off,
	output logic             dither_on,
	output logic      [3:0]  dither_step
);

	function automatic logic [11:0] deglitch_cycles(input logic [1:0] sel);
		unique case (sel)
			2'h0: deglitch_cycles = OC_DEG0_CYC;
			2'h1: deglitch_cycles = OC_DEG1_CYC;
			2'h2: deglitch_cycles = OC_DEG2_CYC;
			2'h3: deglitch_cycles = OC_DEG3_CYC;
		endcase
	endfunction : deglitch_cycles

	fpm_pins_t     meta_reg;
	fpm_pins_t     pins_reg;
	logic          sleep_prev_reg;
	logic          motor_seen_ok_reg;
	logic          dither_off_reg;
	logic          retry_sel_reg;
	logic [1:0]    deglitch_sel_reg;
	logic          fault_bit_reg;
	logic          supply_low_bit_reg;
	logic          pump_low_bit_reg;
	logic          logic_power_ok_bit_reg;
	logic          overcurrent_bit_reg;
	logic [3:0]    lowside_overcurrent_flags_reg;
	logic [3:0]    highside_overcurrent_flags_reg;
	logic [11:0]   limit_cnt_reg;
	logic [19:0]   retry_cnt_reg;
	fpm_oc_state_t oc_state_reg;
	logic [11:0]   dwell_cnt_reg;
	logic          dither_up_reg;
	logic [31:0]   readdata_reg;
	logic          waitrequest_reg;
	logic          fault_out_n_reg;
	logic          bridge_hiz_reg;
	logic          pump_off_reg;
	logic          dither_on_reg;
	logic [3:0]    dither_step_reg;

	logic          bus_write;
	logic          clear_faults_cmd;
	logic          sleep_pulse;
	logic          clr_pulse;
	logic          any_limit;
	logic          retry_eff;
	logic          oc_declare;
	logic          oc_off;

	// two flops on every asynchronous pin
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_reg <= PINS_RST;
			pins_reg <= PINS_RST;
		end else begin
			meta_reg <= pins;
			pins_reg <= meta_reg;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sleep_prev_reg <= 1'b1;
		end else begin
			sleep_prev_reg <= pins_reg.sleep_reset_pin_n;
		end
	end

	// a reset pulse on the sleep pin ends on its rising edge
	assign bus_write        = avs_write & ~waitrequest_reg;
	assign clear_faults_cmd = bus_write & (avs_address == CONTROL_OFS)
	                          & avs_writedata[CT_CLEAR_POS];
	assign sleep_pulse      = pins_reg.sleep_reset_pin_n & ~sleep_prev_reg;
	assign clr_pulse        = clear_faults_cmd | sleep_pulse;
	assign any_limit        = |{pins_reg.limit_low, pins_reg.limit_high};
	assign retry_eff        = pins_reg.hw_mode ? pins_reg.enable_high
	                                           : retry_sel_reg;
	assign oc_declare       = (oc_state_reg == OC_IDLE) & any_limit
	                          & (limit_cnt_reg >= deglitch_cycles(deglitch_sel_reg) - 12'h1);
	assign oc_off           = (oc_state_reg != OC_IDLE);

	// bus: one wait state per access; held off through reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			waitrequest_reg <= 1'b1;
		end else begin
			waitrequest_reg <= ~((avs_read | avs_write) & waitrequest_reg);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			readdata_reg <= 32'h0;
		end else if (avs_read & waitrequest_reg) begin
			unique case (avs_address)
				STATUS_OFS: begin
					readdata_reg <= 32'h0;
					readdata_reg[ST_FAULT_POS]    <= fault_bit_reg;
					readdata_reg[ST_SUPPLY_POS]   <= supply_low_bit_reg;
					readdata_reg[ST_PUMP_POS]     <= pump_low_bit_reg;
					readdata_reg[ST_LOGIC_OK_POS] <= logic_power_ok_bit_reg;
					readdata_reg[ST_OVERCUR_POS]  <= overcurrent_bit_reg;
				end
				OCFLAG_OFS: begin
					readdata_reg <= 32'h0;
					readdata_reg[OCF_LOW_POS +: 4]  <= lowside_overcurrent_flags_reg;
					readdata_reg[OCF_HIGH_POS +: 4] <= highside_overcurrent_flags_reg;
				end
				CONTROL_OFS: begin
					readdata_reg <= 32'h0;
					readdata_reg[CT_DITHER_OFF_POS]  <= dither_off_reg;
					readdata_reg[CT_RETRY_SEL_POS]   <= retry_sel_reg;
					readdata_reg[CT_DEGLITCH_POS +: 2] <= deglitch_sel_reg;
				end
				default: begin
					readdata_reg <= 32'h0;
				end
			endcase
		end
	end

	// control; the clear bit is a strobe and is never stored
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dither_off_reg   <= DITHER_OFF_RST;
			retry_sel_reg    <= RETRY_SEL_RST;
			deglitch_sel_reg <= DEGLITCH_SEL_RST;
		end else if (bus_write & (avs_address == CONTROL_OFS)) begin
			dither_off_reg   <= avs_writedata[CT_DITHER_OFF_POS];
			retry_sel_reg    <= avs_writedata[CT_RETRY_SEL_POS];
			deglitch_sel_reg <= avs_writedata[CT_DEGLITCH_POS +: 2];
		end
	end

	// supply-low only latches after the supply has once been good,
	// so the power-up ramp itself leaves it at zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			motor_seen_ok_reg <= 1'b0;
		end else if (~pins_reg.motor_uv) begin
			motor_seen_ok_reg <= 1'b1;
		end
	end

	// latched status; a set in the clearing cycle wins
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			supply_low_bit_reg     <= 1'b0;
			pump_low_bit_reg       <= 1'b0;
			logic_power_ok_bit_reg <= 1'b0;
		end else begin
			supply_low_bit_reg     <= (pins_reg.motor_uv & motor_seen_ok_reg)
			                          | (supply_low_bit_reg & ~clr_pulse);
			pump_low_bit_reg       <= pins_reg.pump_uv
			                          | (pump_low_bit_reg & ~clr_pulse);
			logic_power_ok_bit_reg <= ~pins_reg.logic_uv
			                          & (logic_power_ok_bit_reg | clr_pulse);
		end
	end

	// summary fault follows live motor and pump supply conditions and the overcurrent shutdown state
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fault_bit_reg <= 1'b0;
		end else begin
			fault_bit_reg <= pins_reg.motor_uv | pins_reg.pump_uv | oc_off
			                 | oc_declare;
		end
	end

	// overcurrent deglitch counter
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			limit_cnt_reg <= 12'h0;
		end else if (~any_limit | oc_off) begin
			limit_cnt_reg <= 12'h0;
		end else if (limit_cnt_reg != 12'hfff) begin
			limit_cnt_reg <= limit_cnt_reg + 12'h1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			overcurrent_bit_reg            <= 1'b0;
			lowside_overcurrent_flags_reg  <= 4'h0;
			highside_overcurrent_flags_reg <= 4'h0;
		end else begin
			overcurrent_bit_reg <= oc_declare | (overcurrent_bit_reg & ~clr_pulse);
			lowside_overcurrent_flags_reg <= ({4{oc_declare}} & pins_reg.limit_low)
				| (lowside_overcurrent_flags_reg & {4{~clr_pulse}});
			highside_overcurrent_flags_reg <= ({4{oc_declare}} & pins_reg.limit_high)
				| (highside_overcurrent_flags_reg & {4{~clr_pulse}});
		end
	end

	// overcurrent shutdown: latched or timed retry
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			oc_state_reg  <= OC_IDLE;
			retry_cnt_reg <= 20'h0;
		end else begin
			unique case (oc_state_reg)
				OC_IDLE: begin
					retry_cnt_reg <= 20'h0;
					if (oc_declare) begin
						oc_state_reg <= OC_FAULT;
					end
				end
				OC_FAULT: begin
					retry_cnt_reg <= 20'h0;
					if (~any_limit & clr_pulse) begin
						oc_state_reg <= OC_IDLE;
					end else if (~any_limit & retry_eff) begin
						oc_state_reg <= OC_WAIT;
					end
				end
				OC_WAIT: begin
					if (any_limit | ~retry_eff) begin
						oc_state_reg <= OC_FAULT;
					end else if (clr_pulse |
					             (retry_cnt_reg >= 20'(RETRY_CYCLES - 1))) begin
						oc_state_reg <= OC_IDLE;
					end else begin
						retry_cnt_reg <= retry_cnt_reg + 20'h1;
					end
				end
				default: begin
					oc_state_reg <= OC_IDLE;
				end
			endcase
		end
	end

	// power stage and fault pin; logic supply loss is silent on the pin
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fault_out_n_reg <= 1'b1;
			bridge_hiz_reg  <= 1'b1;
			pump_off_reg    <= 1'b1;
		end else begin
			fault_out_n_reg <= ~(pins_reg.motor_uv | pins_reg.pump_uv | oc_off
			                     | oc_declare);
			bridge_hiz_reg  <= pins_reg.motor_uv | pins_reg.pump_uv
			                   | pins_reg.logic_uv | oc_off
			                   | oc_declare;
			pump_off_reg    <= pins_reg.motor_uv | pins_reg.logic_uv;
		end
	end

	// dither enable
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dither_on_reg <= 1'b0;
		end else begin
			dither_on_reg <= ~dither_off_reg & ~silent_step_active
			                 & ~pins_reg.hw_mode;
		end
	end

	// triangle walk of the clock step; parks at center when off
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dwell_cnt_reg   <= 12'h0;
			dither_up_reg   <= 1'b1;
			dither_step_reg <= DITHER_CENTER;
		end else if (~dither_on_reg) begin
			dwell_cnt_reg   <= 12'h0;
			dither_up_reg   <= 1'b1;
			dither_step_reg <= DITHER_CENTER;
		end else if (dwell_cnt_reg < DITHER_DWELL_CYC - 12'h1) begin
			dwell_cnt_reg <= dwell_cnt_reg + 12'h1;
		end else begin
			dwell_cnt_reg <= 12'h0;
			if (dither_up_reg) begin
				if (dither_step_reg == DITHER_TOP) begin
					dither_up_reg   <= 1'b0;
					dither_step_reg <= dither_step_reg - 4'h1;
				end else begin
					dither_step_reg <= dither_step_reg + 4'h1;
				end
			end else begin
				if (dither_step_reg == 4'h0) begin
					dither_up_reg   <= 1'b1;
					dither_step_reg <= 4'h1;
				end else begin
					dither_step_reg <= dither_step_reg - 4'h1;
				end
			end
		end
	end

	assign avs_readdata    = readdata_reg;
	assign avs_waitrequest = waitrequest_reg;
	assign fault_out_n     = fault_out_n_reg;
	assign bridge_hiz      = bridge_hiz_reg;
	assign pump_off        = pump_off_reg;
	assign dither_on       = dither_on_reg;
	assign dither_step     = dither_step_reg;

	default clocking dflt_cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_dither_boot_off: assert property (dither_off_reg |=> ~dither_on_reg)
		else $error("dither running while disabled");
	a_dither_forced_off: assert property
		((silent_step_active | pins_reg.hw_mode) |=> ~dither_on_reg)
		else $error("dither not forced off");
	a_dither_range: assert property
		(dither_on_reg |-> (dither_step_reg <= DITHER_TOP))
		else $error("dither step out of range");
	a_motor_uv_stop: assert property
		(pins_reg.motor_uv |=> bridge_hiz_reg & pump_off_reg & ~fault_out_n_reg)
		else $error("motor undervoltage not handled");
	a_all_good_run: assert property
		((~pins_reg.motor_uv & ~pins_reg.pump_uv & ~pins_reg.logic_uv & ~oc_off
		  & ~any_limit) |=> ~bridge_hiz_reg & ~pump_off_reg & fault_out_n_reg)
		else $error("no automatic recovery");
	a_supply_low_hold: assert property
		((supply_low_bit_reg & ~clr_pulse) |=> supply_low_bit_reg)
		else $error("supply-low bit lost");
	a_pump_uv_pump_on: assert property
		((pins_reg.pump_uv & ~pins_reg.motor_uv & ~pins_reg.logic_uv)
		 |=> ~pump_off_reg & ~fault_out_n_reg & pump_low_bit_reg)
		else $error("pump undervoltage wrong");
	a_logic_uv_quiet: assert property
		((pins_reg.logic_uv & ~pins_reg.motor_uv & ~pins_reg.pump_uv & ~oc_off
		  & ~any_limit) |=> fault_out_n_reg & bridge_hiz_reg & pump_off_reg)
		else $error("logic undervoltage wrong");
	a_logic_ok_held: assert property
		(pins_reg.logic_uv |=> ~logic_power_ok_bit_reg ##1
		 (~logic_power_ok_bit_reg | $past(clr_pulse)))
		else $error("logic-ok bit not held");
	a_latch_waits: assert property
		((oc_state_reg == OC_FAULT & ~clr_pulse & ~retry_eff)
		 |=> oc_state_reg == OC_FAULT)
		else $error("latched shutdown released");
	a_clear_all: assert property
		((clr_pulse & ~pins_reg.pump_uv & ~oc_declare)
		 |=> ~pump_low_bit_reg & ~overcurrent_bit_reg)
		else $error("clear did not clear");

endmodule : fpm_fault_manager

// [shared/fpm_pkg.sv]
/*
 * fpm_pkg: register map, reset values, timing constants and pin bundle of
 * the fault protection manager.
 * assumes a 200 MHz core clock and a 32-bit Avalon-MM register port.
 */
package fpm_pkg;

	// clock
	localparam int CLK_MHZ = 200;

	// register byte offsets
	localparam logic [3:0] STATUS_OFS  = 4'h0;
	localparam logic [3:0] OCFLAG_OFS  = 4'h4;
	localparam logic [3:0] CONTROL_OFS = 4'h8;

	// status fields
	localparam int ST_FAULT_POS     = 0;
	localparam int ST_SUPPLY_POS    = 1;
	localparam int ST_PUMP_POS      = 2;
	localparam int ST_LOGIC_OK_POS  = 3;
	localparam int ST_OVERCUR_POS   = 4;

	// overcurrent flag fields
	localparam int OCF_LOW_POS  = 0;
	localparam int OCF_HIGH_POS = 4;

	// control fields
	localparam int CT_DITHER_OFF_POS = 0;
	localparam int CT_RETRY_SEL_POS  = 1;
	localparam int CT_DEGLITCH_POS   = 2;
	localparam int CT_CLEAR_POS      = 4;

	// control reset values
	localparam logic       DITHER_OFF_RST   = 1'b1;
	localparam logic       RETRY_SEL_RST    = 1'b0;
	localparam logic [1:0] DEGLITCH_SEL_RST = 2'h0;

	// overcurrent deglitch choices, least times rounded up
	localparam int OC_DEG0_NS = 1000;
	localparam int OC_DEG1_NS = 2000;
	localparam int OC_DEG2_NS = 4000;
	localparam int OC_DEG3_NS = 8000;
	localparam logic [11:0] OC_DEG0_CYC = 12'((OC_DEG0_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] OC_DEG1_CYC = 12'((OC_DEG1_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] OC_DEG2_CYC = 12'((OC_DEG2_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] OC_DEG3_CYC = 12'((OC_DEG3_NS * CLK_MHZ + 999) / 1000);

	// automatic retry wait
	localparam int RETRY_NS  = 4000000;
	localparam int RETRY_CYC = (RETRY_NS / 1000) * CLK_MHZ;

	// dither: 14 equal steps, dwell time per step
	localparam int         DITHER_STEPS   = 14;
	localparam logic [3:0] DITHER_TOP     = 4'(DITHER_STEPS - 1);
	localparam logic [3:0] DITHER_CENTER  = 4'h7;
	localparam int         DITHER_DWELL_NS = 1000;
	localparam logic [11:0] DITHER_DWELL_CYC = 12'((DITHER_DWELL_NS * CLK_MHZ) / 1000);

	// pins from the analog side and straps
	typedef struct packed {
		logic       motor_uv;
		logic       pump_uv;
		logic       logic_uv;
		logic       sleep_reset_pin_n;
		logic       hw_mode;
		logic       enable_high;
		logic [3:0] limit_low;
		logic [3:0] limit_high;
	} fpm_pins_t;

	// synchroniser reset: supply low until proven good, sleep pin idle high
	localparam fpm_pins_t PINS_RST = '{
		motor_uv: 1'b1, pump_uv: 1'b0, logic_uv: 1'b0,
		sleep_reset_pin_n: 1'b1, hw_mode: 1'b0, enable_high: 1'b0,
		limit_low: 4'h0, limit_high: 4'h0};

	typedef enum logic [1:0] {
		OC_IDLE  = 2'b00,
		OC_FAULT = 2'b01,
		OC_WAIT  = 2'b10
	} fpm_oc_state_t;

endpackage : fpm_pkg
